// file: inc/xps_pkg.sv
// Constants, field layouts and types of the transmitter port setup sequencer.
// Assumes the transceiver control bus adapter takes one address/value write per request.
// Behaviour
// - Order: page, format, clocking, divider, driver, source, power
// - First write puts 00 into address 7F
// - Converter master: address 03 gets 00 or 01
// - Converter master: address 04 gets 00
// - Address 07 gets 64, 24 or 04 by rate
// - Address 08 gets 00, driver enabled
// - Address 09 gets 01, page-two buffers source
// - Without buffer load, last write puts 34 into address 01
// - Converter slave: address 03 gets 08 or 09
// - Converter slave: address 04 gets 03, 01, 00
// - Load: disable, page two, data, page zero, enable
// - Only left-justified or I2S framing, never TDM
// - Rates 8kHz to 216kHz via matching divider settings
package xps_pkg;
   // Register byte addresses on the Avalon side
   localparam logic [7:0] ADR_CTRL = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h04;
   localparam logic [7:0] ADR_CU_COUNT = 8'h08;
   localparam logic [7:0] ADR_CU_ENTRY = 8'h0c;
   // Control register fields
   localparam int CTRL_START = 0;
   localparam int CTRL_SLAVE = 1;
   localparam int CTRL_FMT_LO = 2;
   localparam int CTRL_RATE_LO = 4;
   localparam int CTRL_CU_LOAD = 6;
   // Status register fields
   localparam int STAT_BUSY = 0;
   localparam int STAT_DONE = 1;
   localparam int STAT_ERR = 2;
   // Buffer entry fields
   localparam int ENTRY_DATA_LO = 0;
   localparam int ENTRY_ADDR_LO = 8;
   localparam int ENTRY_IDX_LO = 16;
   // Serial framing and rate codes
   localparam logic [1:0] FMT_LJ = 2'h0;
   localparam logic [1:0] FMT_I2S = 2'h1;
   localparam logic [1:0] RATE_NORMAL = 2'h0;
   localparam logic [1:0] RATE_DOUBLE = 2'h1;
   localparam logic [1:0] RATE_QUAD = 2'h2;
   // Transceiver register addresses
   localparam logic [7:0] XA_PAGE = 8'h7f;
   localparam logic [7:0] XA_PORT_FMT = 8'h03;
   localparam logic [7:0] XA_PORT_CLK = 8'h04;
   localparam logic [7:0] XA_TX_DIV = 8'h07;
   localparam logic [7:0] XA_LINE = 8'h08;
   localparam logic [7:0] XA_BUF_SRC = 8'h09;
   localparam logic [7:0] XA_POWER = 8'h01;
   // Transceiver register values
   localparam logic [7:0] XV_PAGE0 = 8'h00;
   localparam logic [7:0] XV_PAGE2 = 8'h02;
   localparam logic [7:0] XV_FMT_LJ_SLV = 8'h00;
   localparam logic [7:0] XV_FMT_I2S_SLV = 8'h01;
   localparam logic [7:0] XV_FMT_LJ_MST = 8'h08;
   localparam logic [7:0] XV_FMT_I2S_MST = 8'h09;
   localparam logic [7:0] XV_CLK_DEFAULT = 8'h00;
   localparam logic [7:0] XV_PCLK_512 = 8'h03;
   localparam logic [7:0] XV_PCLK_256 = 8'h01;
   localparam logic [7:0] XV_PCLK_128 = 8'h00;
   localparam logic [7:0] XV_DIV_512 = 8'h64;
   localparam logic [7:0] XV_DIV_256 = 8'h24;
   localparam logic [7:0] XV_DIV_128 = 8'h04;
   localparam logic [7:0] XV_LINE_ON = 8'h00;
   localparam logic [7:0] XV_BUF_SRC_PAGE2 = 8'h01;
   localparam logic [7:0] XV_POWER_UP = 8'h34;
   // Sequence steps
   localparam int STEP_W = 4;
   localparam logic [3:0] STEP_PAGE = 4'h0;
   localparam logic [3:0] STEP_FMT = 4'h1;
   localparam logic [3:0] STEP_CLK = 4'h2;
   localparam logic [3:0] STEP_DIV = 4'h3;
   localparam logic [3:0] STEP_LINE = 4'h4;
   localparam logic [3:0] STEP_SRC = 4'h5;
   localparam logic [3:0] STEP_POWER = 4'h6;
   localparam logic [3:0] STEP_XFER_DIS = 4'h7;
   localparam logic [3:0] STEP_PAGE2 = 4'h8;
   localparam logic [3:0] STEP_PAGE0 = 4'h9;
   localparam logic [3:0] STEP_XFER_EN = 4'ha;
   // Reset values
   localparam logic [31:0] RDATA_RST = 32'h0000_0000;
   localparam logic [7:0] BYTE_RST = 8'h00;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } xps_wr_type;

   typedef struct packed {
      logic slave;
      logic [1:0] fmt;
      logic [1:0] rate;
      logic cu_load;
   } xps_cfg_type;

   localparam xps_cfg_type CFG_RST = '{slave: 1'b0, fmt: FMT_LJ, rate: RATE_NORMAL, cu_load: 1'b0};
   localparam xps_wr_type WR_RST = '{addr: BYTE_RST, data: BYTE_RST};

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_CUBUF = 3'b100
   } xps_state_type;
endpackage : xps_pkg

// file: verilog/xps_step_table.sv
// Address/value table of the transceiver setup sequence.
// Assumes the caller holds step and configuration stable while a write is pending.
`timescale 1ns/10ps
`default_nettype none
module xps_step_table
   import xps_pkg::*;
#(
   parameter int unsigned XFER_DIS_POS = 2
) (
   input wire logic [STEP_W-1:0] step,
   input wire xps_cfg_type cfg,
   output xps_wr_type wr
);
   localparam logic [7:0] XFER_DIS_BIT = 8'(8'h01 << XFER_DIS_POS);

   always_comb begin
      wr = WR_RST;
      case (step)
         STEP_PAGE: wr = '{addr: XA_PAGE, data: XV_PAGE0};
         STEP_FMT: begin
            wr.addr = XA_PORT_FMT;
            if (cfg.slave) begin
               wr.data = (cfg.fmt == FMT_I2S) ? XV_FMT_I2S_MST : XV_FMT_LJ_MST;
            end else begin
               wr.data = (cfg.fmt == FMT_I2S) ? XV_FMT_I2S_SLV : XV_FMT_LJ_SLV;
            end
         end
         STEP_CLK: begin
            wr.addr = XA_PORT_CLK;
            if (!cfg.slave) begin
               wr.data = XV_CLK_DEFAULT;
            end else if (cfg.rate == RATE_QUAD) begin
               wr.data = XV_PCLK_128;
            end else if (cfg.rate == RATE_DOUBLE) begin
               wr.data = XV_PCLK_256;
            end else begin
               wr.data = XV_PCLK_512;
            end
         end
         STEP_DIV: begin
            wr.addr = XA_TX_DIV;
            if (cfg.rate == RATE_QUAD) begin
               wr.data = XV_DIV_128;
            end else if (cfg.rate == RATE_DOUBLE) begin
               wr.data = XV_DIV_256;
            end else begin
               wr.data = XV_DIV_512;
            end
         end
         STEP_LINE: wr = '{addr: XA_LINE, data: XV_LINE_ON};
         STEP_SRC: wr = '{addr: XA_BUF_SRC, data: XV_BUF_SRC_PAGE2};
         STEP_POWER: wr = '{addr: XA_POWER, data: XV_POWER_UP};
         STEP_XFER_DIS: wr = '{addr: XA_LINE, data: XV_LINE_ON | XFER_DIS_BIT};
         STEP_PAGE2: wr = '{addr: XA_PAGE, data: XV_PAGE2};
         STEP_PAGE0: wr = '{addr: XA_PAGE, data: XV_PAGE0};
         STEP_XFER_EN: wr = '{addr: XA_LINE, data: XV_LINE_ON};
         default: wr = WR_RST;
      endcase
   end
endmodule : xps_step_table
`default_nettype wire

// file: verilog/xps_sequencer.sv
// Top of the transmitter port setup sequencer: Avalon-MM slave registers and write sequencing.
// Assumes a control bus adapter that answers each held write request with a one-cycle acknowledge.
//
// Implementation choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module xps_sequencer
   import xps_pkg::*;
#(
   parameter int unsigned CU_DEPTH = 16,
   parameter int unsigned XFER_DIS_POS = 2
) (
   input wire logic SYS_CLK,
   input wire logic RST,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic XCVR_WR_REQ,
   output xps_wr_type XCVR_WR,
   input wire logic XCVR_WR_ACK,
   output logic BUSY,
   output logic DONE,
   output logic CFG_ERROR
);
   localparam int CU_AW = $clog2(CU_DEPTH);

   generate
      if (CU_DEPTH < 2 || CU_DEPTH > 256 || (CU_DEPTH & (CU_DEPTH - 1)) != 0) begin : g_bad_depth
         $error("CU_DEPTH must be a power of two from 2 to 256");
      end
      if (XFER_DIS_POS > 7) begin : g_bad_xfer
         $error("XFER_DIS_POS must lie within one byte");
      end
   endgenerate

   xps_state_type state_q;
   logic [STEP_W-1:0] step_q;
   logic [CU_AW-1:0] cu_idx_q;
   logic [CU_AW:0] cu_count_q;
   xps_cfg_type cfg_q;
   xps_wr_type cu_mem_q [CU_DEPTH];
   xps_wr_type tbl_wr;
   xps_wr_type wr_q;
   logic req_q;
   logic busy_q;
   logic done_q;
   logic err_q;
   logic wait_q;
   logic [31:0] rdata_q;
   logic wr_strobe;
   logic start_req;
   logic start_ok;
   logic start_bad;
   logic wr_done;
   logic finish;
   xps_cfg_type cfg_new;
   logic [CU_AW:0] count_new;

   function automatic logic cfg_valid(input xps_cfg_type c);
      cfg_valid = (c.fmt == FMT_LJ || c.fmt == FMT_I2S)
         && (c.rate == RATE_NORMAL || c.rate == RATE_DOUBLE || c.rate == RATE_QUAD);
   endfunction : cfg_valid

   function automatic logic [31:0] read_mux(input logic [7:0] a, input xps_cfg_type c,
                                            input logic [3:0] st, input logic [CU_AW:0] n);
      read_mux = RDATA_RST;
      if (a == ADR_CTRL) begin
         read_mux[CTRL_SLAVE] = c.slave;
         read_mux[CTRL_FMT_LO +: 2] = c.fmt;
         read_mux[CTRL_RATE_LO +: 2] = c.rate;
         read_mux[CTRL_CU_LOAD] = c.cu_load;
      end else if (a == ADR_STATUS) begin
         read_mux[3:0] = st;
      end else if (a == ADR_CU_COUNT) begin
         read_mux[CU_AW:0] = n;
      end
   endfunction : read_mux

   // Bus write effect happens at the edge where waitrequest is sampled low
   assign wr_strobe = AVS_WRITE && !wait_q;
   assign start_req = wr_strobe && AVS_ADDRESS == ADR_CTRL && AVS_WRITEDATA[CTRL_START] && !busy_q;
   assign cfg_new = '{slave: AVS_WRITEDATA[CTRL_SLAVE], fmt: AVS_WRITEDATA[CTRL_FMT_LO +: 2],
                      rate: AVS_WRITEDATA[CTRL_RATE_LO +: 2], cu_load: AVS_WRITEDATA[CTRL_CU_LOAD]};
   assign start_ok = start_req && cfg_valid(cfg_new);
   assign start_bad = start_req && !cfg_valid(cfg_new);
   assign wr_done = req_q && XCVR_WR_ACK;
   assign finish = wr_done && ((state_q == ST_RUN && step_q == STEP_POWER && !cfg_q.cu_load)
                   || (state_q == ST_RUN && step_q == STEP_XFER_EN));
   assign count_new = (AVS_WRITEDATA > 32'(CU_DEPTH)) ? (CU_AW+1)'(CU_DEPTH)
                      : AVS_WRITEDATA[CU_AW:0];

   xps_step_table #(
      .XFER_DIS_POS(XFER_DIS_POS)
   ) u_table (
      .step(step_q),
      .cfg(cfg_q),
      .wr(tbl_wr)
   );

   // Waitrequest: one wait cycle, then one answer cycle
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         wait_q <= 1'b1;
      end else if ((AVS_READ || AVS_WRITE) && wait_q) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rdata_q <= RDATA_RST;
      end else if (AVS_READ && wait_q) begin
         rdata_q <= read_mux(AVS_ADDRESS, cfg_q, {1'b0, err_q, done_q, busy_q}, cu_count_q);
      end
   end

   // Configuration is frozen while a sequence runs
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cfg_q <= CFG_RST;
      end else if (wr_strobe && AVS_ADDRESS == ADR_CTRL && !busy_q) begin
         cfg_q <= cfg_new;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         cu_count_q <= '0;
      end else if (wr_strobe && AVS_ADDRESS == ADR_CU_COUNT && !busy_q) begin
         cu_count_q <= count_new;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (wr_strobe && AVS_ADDRESS == ADR_CU_ENTRY && !busy_q) begin
         cu_mem_q[AVS_WRITEDATA[ENTRY_IDX_LO +: CU_AW]] <= '{addr: AVS_WRITEDATA[ENTRY_ADDR_LO +: 8],
                                                            data: AVS_WRITEDATA[ENTRY_DATA_LO +: 8]};
      end
   end

   // Sequence state
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         state_q <= ST_IDLE;
         step_q <= STEP_PAGE;
         cu_idx_q <= '0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (start_ok) begin
                  state_q <= ST_RUN;
                  step_q <= STEP_PAGE;
               end
            end
            ST_RUN: begin
               if (finish) begin
                  state_q <= ST_IDLE;
               end else if (wr_done && step_q == STEP_PAGE2) begin
                  if (cu_count_q != '0) begin
                     state_q <= ST_CUBUF;
                     cu_idx_q <= '0;
                  end else begin
                     step_q <= STEP_PAGE0;
                  end
               end else if (wr_done) begin
                  step_q <= step_q + 4'h1;
               end
            end
            ST_CUBUF: begin
               if (wr_done) begin
                  if ({1'b0, cu_idx_q} == cu_count_q - (CU_AW+1)'(1)) begin
                     state_q <= ST_RUN;
                     step_q <= STEP_PAGE0;
                  end else begin
                     cu_idx_q <= cu_idx_q + (CU_AW)'(1);
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Each write is held until acknowledged before the next is issued
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         req_q <= 1'b0;
         wr_q <= WR_RST;
      end else if (wr_done) begin
         req_q <= 1'b0;
      end else if (!req_q && state_q == ST_RUN) begin
         req_q <= 1'b1;
         wr_q <= tbl_wr;
      end else if (!req_q && state_q == ST_CUBUF) begin
         req_q <= 1'b1;
         wr_q <= cu_mem_q[cu_idx_q];
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         busy_q <= 1'b0;
      end else if (start_ok) begin
         busy_q <= 1'b1;
      end else if (finish) begin
         busy_q <= 1'b0;
      end
   end

   // Done rises only after the power-up write and any buffer loading
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         done_q <= 1'b0;
      end else if (finish) begin
         done_q <= 1'b1;
      end else if (start_ok || start_bad) begin
         done_q <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         err_q <= 1'b0;
      end else if (start_bad) begin
         err_q <= 1'b1;
      end else if (start_ok) begin
         err_q <= 1'b0;
      end
   end

   assign AVS_READDATA = rdata_q;
   assign AVS_WAITREQUEST = wait_q;
   assign XCVR_WR_REQ = req_q;
   assign XCVR_WR = wr_q;
   assign BUSY = busy_q;
   assign DONE = done_q;
   assign CFG_ERROR = err_q;

   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);

   a_req_held: assert property (req_q && !XCVR_WR_ACK |=> req_q && $stable(wr_q))
      else $error("write request dropped or changed before acknowledge");
   a_first_page: assert property (start_ok |-> ##2 req_q && wr_q.addr == XA_PAGE && wr_q.data == XV_PAGE0)
      else $error("first write is not page zero select");
   a_mst_format: assert property (req_q && state_q == ST_RUN && step_q == STEP_FMT && !cfg_q.slave
      |-> wr_q.data == ((cfg_q.fmt == FMT_I2S) ? XV_FMT_I2S_SLV : XV_FMT_LJ_SLV))
      else $error("port format wrong for converter master");
   a_slv_format: assert property (req_q && state_q == ST_RUN && step_q == STEP_FMT && cfg_q.slave
      |-> wr_q.data == ((cfg_q.fmt == FMT_I2S) ? XV_FMT_I2S_MST : XV_FMT_LJ_MST))
      else $error("port format wrong for converter slave");
   a_mst_clock: assert property (req_q && state_q == ST_RUN && step_q == STEP_CLK && !cfg_q.slave
      |-> wr_q.addr == XA_PORT_CLK && wr_q.data == XV_CLK_DEFAULT)
      else $error("port clocking not default for converter master");
   a_slv_clock: assert property (req_q && state_q == ST_RUN && step_q == STEP_CLK && cfg_q.slave
      && cfg_q.rate == RATE_NORMAL |-> wr_q.data == XV_PCLK_512)
      else $error("port clock divider wrong for normal rate");
   a_tx_divider: assert property (req_q && state_q == ST_RUN && step_q == STEP_DIV && cfg_q.rate == RATE_QUAD
      |-> wr_q.addr == XA_TX_DIV && wr_q.data == XV_DIV_128)
      else $error("transmit divider wrong for quad rate");
   a_line_on: assert property (req_q && state_q == ST_RUN && step_q == STEP_LINE
      |-> wr_q.addr == XA_LINE && wr_q.data == XV_LINE_ON)
      else $error("line driver write wrong");
   a_buf_source: assert property (wr_done && state_q == ST_RUN && step_q == STEP_LINE
      |=> ##1 wr_q.addr == XA_BUF_SRC && wr_q.data == XV_BUF_SRC_PAGE2)
      else $error("buffer source write does not follow line driver");
   a_power_last: assert property (finish && !cfg_q.cu_load
      |-> wr_q.addr == XA_POWER && wr_q.data == XV_POWER_UP)
      else $error("base sequence does not end with power-up");
   a_step_order: assert property (wr_done && state_q == ST_RUN && step_q < STEP_POWER
      |=> step_q == $past(step_q) + 4'h1)
      else $error("sequence step skipped");
   a_page2_enter: assert property (wr_done && state_q == ST_RUN && step_q == STEP_XFER_DIS
      |=> ##1 wr_q.addr == XA_PAGE && wr_q.data == XV_PAGE2)
      else $error("page two not selected after transfer disable");
   a_done_rise: assert property ($rose(done_q) |-> $past(XCVR_WR_ACK) && !busy_q)
      else $error("done raised without final acknowledge");
   a_tdm_refused: assert property (start_bad |=> err_q && !busy_q && state_q == ST_IDLE)
      else $error("invalid framing or rate was not refused");
   a_one_write: assert property (wr_done |=> !req_q)
      else $error("next write issued in the acknowledging cycle");
   a_xfer_disable: assert property (req_q && state_q == ST_RUN && step_q == STEP_XFER_DIS
      |-> wr_q.addr == XA_LINE && wr_q.data[XFER_DIS_POS])
      else $error("buffer transfers not disabled before page two");
   a_xfer_enable: assert property (finish && cfg_q.cu_load
      |-> wr_q.addr == XA_LINE && wr_q.data == XV_LINE_ON)
      else $error("buffer transfers not enabled at the end");
   a_slv_clk_quad: assert property (req_q && state_q == ST_RUN && step_q == STEP_CLK && cfg_q.slave
      && cfg_q.rate == RATE_QUAD |-> wr_q.data == XV_PCLK_128)
      else $error("port clock divider wrong for quad rate");
   a_div_normal: assert property (req_q && state_q == ST_RUN && step_q == STEP_DIV
      && cfg_q.rate == RATE_NORMAL |-> wr_q.data == XV_DIV_512)
      else $error("transmit divider wrong for normal rate");

   c_master_run: cover property (finish && !cfg_q.slave && !cfg_q.cu_load);
   c_slave_run: cover property (finish && cfg_q.slave);
   c_buffer_load: cover property (wr_done && state_q == ST_CUBUF);
   c_refused: cover property (start_bad);
   c_empty_load: cover property (wr_done && state_q == ST_RUN && step_q == STEP_PAGE2 && cu_count_q == '0);
endmodule : xps_sequencer
`default_nettype wire

// file: bench/xps_xcvr_model.sv
// Behavioural model of the transceiver control port: page, power and acknowledge of each write.
// Assumes the sequencer holds request and write pair until the acknowledging edge.
`timescale 1ns/10ps
`default_nettype none
module xps_xcvr_model
   import xps_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [3:0] ack_delay,
   input wire logic wr_req,
   input wire xps_wr_type wr,
   output logic ack_q,
   output logic [7:0] page_q,
   output logic [7:0] power_q
);
   logic [3:0] wait_q;

   // One acknowledge pulse per pending write, after ack_delay cycles
   always_ff @(posedge clk) begin
      if (rst || !wr_req || ack_q) begin
         ack_q <= 1'b0;
         wait_q <= 4'h0;
      end else if (wait_q == ack_delay) begin
         ack_q <= 1'b1;
      end else begin
         wait_q <= wait_q + 4'h1;
      end
   end

   // Page select and power register of page zero
   always_ff @(posedge clk) begin
      if (rst) begin
         page_q <= 8'h00;
         power_q <= 8'h00;
      end else if (wr_req && ack_q) begin
         if (wr.addr == 8'h7f) page_q <= wr.data;
         if (wr.addr == 8'h01 && page_q == 8'h00) power_q <= wr.data;
      end
   end
endmodule : xps_xcvr_model
`default_nettype wire

// file: bench/testbench.sv
// Self-checking testbench of the transmitter port setup sequencer.
// Assumes the transceiver control port model xps_xcvr_model.
`timescale 1ns/10ps
`default_nettype none
module testbench
   import xps_pkg::*;
;
   localparam int CU_DEPTH = 16;
   localparam int XFER_DIS_POS = 2;
   localparam int LIMIT = 400;
   logic SYS_CLK = 1'b0;
   logic RST = 1'b1;
   logic [7:0] AVS_ADDRESS = 8'h00;
   logic AVS_READ = 1'b0;
   logic AVS_WRITE = 1'b0;
   logic [31:0] AVS_WRITEDATA = 32'h0;
   logic [31:0] AVS_READDATA;
   logic AVS_WAITREQUEST;
   logic XCVR_WR_REQ;
   logic XCVR_WR_ACK;
   logic BUSY;
   logic DONE;
   logic CFG_ERROR;
   xps_wr_type XCVR_WR;
   logic [3:0] ack_delay = 4'h0;
   logic [7:0] page;
   logic [7:0] power;
   logic [31:0] rd;
   logic [7:0] cu_addr [2] = '{8'h40, 8'h58};
   logic [7:0] cu_data [2] = '{8'ha5, 8'h3c};
   xps_wr_type log_q[$];
   xps_wr_type exp_q[$];
   int n_errors = 0;
   int tests_run = 0;

   always #20 SYS_CLK = ~SYS_CLK;

   xps_sequencer #(.CU_DEPTH(CU_DEPTH), .XFER_DIS_POS(XFER_DIS_POS)) xps_sequencer_inst (
      .SYS_CLK(SYS_CLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
      .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
      .AVS_WAITREQUEST(AVS_WAITREQUEST), .XCVR_WR_REQ(XCVR_WR_REQ), .XCVR_WR(XCVR_WR),
      .XCVR_WR_ACK(XCVR_WR_ACK), .BUSY(BUSY), .DONE(DONE), .CFG_ERROR(CFG_ERROR)
   );

   xps_xcvr_model xps_xcvr_model_inst (
      .clk(SYS_CLK), .rst(RST), .ack_delay(ack_delay), .wr_req(XCVR_WR_REQ), .wr(XCVR_WR),
      .ack_q(XCVR_WR_ACK), .page_q(page), .power_q(power)
   );

   // Record every completed transceiver write
   always @(posedge SYS_CLK) begin
      if (XCVR_WR_REQ === 1'b1 && XCVR_WR_ACK === 1'b1) log_q.push_back(XCVR_WR);
   end

   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize

   task automatic check32(input string name, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", name, e, g);
         n_errors++;
      end
   endtask : check32

   task automatic check16(input string name, input xps_wr_type e, input xps_wr_type g);
      tests_run++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", name, e, g);
         n_errors++;
      end
   endtask : check16

   task automatic hang(input string what);
      $display("[ERR] %s expected completion seen timeout", what);
      n_errors++;
      summarize();
   endtask : hang

   task automatic av_write(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge SYS_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= 1'b1;
      for (i = 0; i < LIMIT; i++) begin
         @(posedge SYS_CLK);
         if (AVS_WAITREQUEST === 1'b0) break;
      end
      if (i == LIMIT) hang("write");
      AVS_WRITE <= 1'b0;
   endtask : av_write

   task automatic av_read(input logic [7:0] a, output logic [31:0] d);
      int i;
      @(posedge SYS_CLK);
      AVS_ADDRESS <= a;
      AVS_READ <= 1'b1;
      for (i = 0; i < LIMIT; i++) begin
         @(posedge SYS_CLK);
         if (AVS_WAITREQUEST === 1'b0) break;
      end
      if (i == LIMIT) hang("read");
      d = AVS_READDATA;
      AVS_READ <= 1'b0;
   endtask : av_read

   task automatic put(input logic [7:0] a, input logic [7:0] d);
      exp_q.push_back('{addr: a, data: d});
   endtask : put

   task automatic expect_seq(input logic slv, input logic [1:0] fmt, input logic [1:0] rate, input logic load,
                             input int n);
      exp_q.delete();
      put(8'h7f, 8'h00);
      put(8'h03, {4'h0, slv, 2'h0, fmt[0]});
      put(8'h04, slv ? ((rate == 2'h0) ? 8'h03 : (rate == 2'h1) ? 8'h01 : 8'h00) : 8'h00);
      put(8'h07, (rate == 2'h0) ? 8'h64 : (rate == 2'h1) ? 8'h24 : 8'h04);
      put(8'h08, 8'h00);
      put(8'h09, 8'h01);
      put(8'h01, 8'h34);
      if (load) begin
         put(8'h08, 8'h01 << XFER_DIS_POS);
         put(8'h7f, 8'h02);
         for (int i = 0; i < n; i++) put(cu_addr[i], cu_data[i]);
         put(8'h7f, 8'h00);
         put(8'h08, 8'h00);
      end
   endtask : expect_seq

   task automatic run(input logic slv, input logic [1:0] fmt, input logic [1:0] rate, input logic load,
                      input logic [31:0] stat, input logic poke);
      int i;
      log_q.delete();
      av_write(ADR_CTRL, {25'h0, load, rate, fmt, slv, 1'b1});
      if (poke) begin
         av_read(ADR_STATUS, rd);
         check32("status running", 32'h1, rd);
         check32("busy pin", 32'h1, {31'h0, BUSY});
         av_write(ADR_CTRL, 32'h0000_0022);
         av_write(ADR_CU_COUNT, 32'h0);
      end
      @(posedge SYS_CLK);
      for (i = 0; i < LIMIT && DONE !== 1'b1 && CFG_ERROR !== 1'b1; i++) @(posedge SYS_CLK);
      if (i == LIMIT) hang("sequence");
      av_read(ADR_STATUS, rd);
      check32("status end", stat, rd);
      check32("status pins", stat, {29'h0, CFG_ERROR, DONE, BUSY});
      check32("write count", 32'(exp_q.size()), 32'(log_q.size()));
      for (i = 0; i < exp_q.size() && i < log_q.size(); i++) check16("write pair", exp_q[i], log_q[i]);
   endtask : run

   initial begin
      repeat (6) @(posedge SYS_CLK);
      RST <= 1'b0;
      @(posedge SYS_CLK);
      av_read(ADR_STATUS, rd);
      check32("status reset", 32'h0, rd);
      av_read(8'h10, rd);
      check32("unmapped read", 32'h0, rd);
      // Every mode, framing and rate, prompt and slow acknowledge
      for (int s = 0; s < 2; s++) begin
         for (int f = 0; f < 2; f++) begin
            for (int r = 0; r < 3; r++) begin
               ack_delay <= 4'(r * 2);
               expect_seq(s[0], f[1:0], r[1:0], 1'b0, 0);
               run(s[0], f[1:0], r[1:0], 1'b0, 32'h2, 1'b0);
            end
         end
      end
      check32("power", 32'h34, {24'h0, power});
      // Buffer load with two entries, config writes while running are ignored
      av_write(ADR_CU_COUNT, 32'h2);
      for (int i = 0; i < 2; i++) av_write(ADR_CU_ENTRY, {12'h0, 4'(i), cu_addr[i], cu_data[i]});
      av_read(ADR_CU_ENTRY, rd);
      check32("entry read", 32'h0, rd);
      ack_delay <= 4'h6;
      expect_seq(1'b0, FMT_I2S, RATE_DOUBLE, 1'b1, 2);
      run(1'b0, FMT_I2S, RATE_DOUBLE, 1'b1, 32'h2, 1'b1);
      check32("page", 32'h0, {24'h0, page});
      // Buffer load with no entries
      ack_delay <= 4'h1;
      av_write(ADR_CU_COUNT, 32'h0);
      expect_seq(1'b1, FMT_LJ, RATE_QUAD, 1'b1, 0);
      run(1'b1, FMT_LJ, RATE_QUAD, 1'b1, 32'h2, 1'b0);
      // Refused framing and rate codes write nothing
      exp_q.delete();
      run(1'b0, 2'h2, RATE_NORMAL, 1'b0, 32'h4, 1'b0);
      run(1'b1, 2'h3, RATE_NORMAL, 1'b0, 32'h4, 1'b0);
      run(1'b0, FMT_LJ, 2'h3, 1'b0, 32'h4, 1'b0);
      expect_seq(1'b0, FMT_LJ, RATE_NORMAL, 1'b0, 0);
      run(1'b0, FMT_LJ, RATE_NORMAL, 1'b0, 32'h2, 1'b0);
      summarize();
   end
endmodule : testbench
`default_nettype wire
